// *** hw/acx_pkg.sv ***
package acx_pkg;

  // Register byte addresses on the processor bus.
  localparam logic [15:0] ACX_ADDR_MODE  = 16'hff78;
  localparam logic [15:0] ACX_ADDR_CTRL  = 16'hff79;
  localparam logic [15:0] ACX_ADDR_SHIFT = 16'hff7a;
  localparam logic [15:0] ACX_ADDR_IVAL  = 16'hff7b;
  localparam logic [15:0] ACX_ADDR_PTR   = 16'hff7c;
  localparam logic [15:0] ACX_ADDR_BUF   = 16'hff80;

  // Field positions of serial_mode_control.
  localparam int ACX_MODE_EN     = 7;
  localparam int ACX_MODE_ORDER  = 6;
  localparam int ACX_MODE_AUTO   = 5;
  localparam int ACX_MODE_IDLE   = 4;
  localparam int ACX_MODE_SEL_HI = 1;
  localparam int ACX_MODE_SEL_LO = 0;

  // Field positions of auto_transfer_control and auto_transfer_interval.
  localparam int ACX_CTRL_RX     = 7;
  localparam int ACX_CTRL_REP    = 6;
  localparam int ACX_CTRL_BUSY   = 3;
  localparam int ACX_IVAL_EN     = 7;
  localparam int ACX_IVAL_HI     = 4;

  // Writable bits of each register; reserved bits always read as zero.
  localparam logic [7:0] ACX_MODE_MASK  = 8'hf3;
  localparam logic [7:0] ACX_CTRL_WMASK = 8'hc0;
  localparam logic [7:0] ACX_IVAL_MASK  = 8'h9f;
  localparam logic [7:0] ACX_PTR_MASK   = 8'h0f;
  localparam logic [7:0] ACX_RESET_VAL  = 8'h00;

  // Clock select code for the external clock; codes 1..3 divide by 2**(code+1).
  localparam logic [1:0] ACX_SEL_EXT = 2'h0;

  // Index of the last bit of a byte.
  localparam logic [3:0] ACX_BIT_LAST = 4'h7;

  // Gap lengths in serial half periods.
  localparam logic [6:0] ACX_GAP_N0    = 7'h05;
  localparam logic [6:0] ACX_GAP_EXTRA = 7'h03;
  localparam logic [6:0] ACX_GAP_FREE  = 7'h01;

  // Engine states.
  typedef enum logic [1:0] {
    ACX_IDLE  = 2'b00,
    ACX_SHIFT = 2'b01,
    ACX_GAP   = 2'b10
  } acx_state_e;

endpackage

// *** hw/acx_sclk_div.sv ***
`timescale 1ns/1ps
module acx_sclk_div
  import acx_pkg::*;
#(
  parameter int CW = 4
) (
  // Clock and reset.
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // Control.
  input  wire logic       run,
  input  wire logic [1:0] sel,
  // Half period enable.
  output logic            half_tick_q
);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] half_len;

  // A half period lasts 2**sel main clocks, so a full period is 2**(sel+1).
  assign half_len = CW'(1) << sel;

  // Free counter that emits one pulse per half period while running.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q       <= '0;
      half_tick_q <= 1'b0;
    end else if (!run) begin
      cnt_q       <= '0;
      half_tick_q <= 1'b0;
    end else if (cnt_q >= half_len - CW'(1)) begin
      cnt_q       <= '0;
      half_tick_q <= 1'b1;
    end else begin
      cnt_q       <= cnt_q + CW'(1);
      half_tick_q <= 1'b0;
    end
  end

endmodule // acx_sclk_div

// *** hw/acx_ctrl.sv ***
// Behaviour
// - Port enable 0 stops shifting, clears bit counter, frees pins; 1 enables.
// - Bit order 0 sends MSB first, 1 sends LSB first.
// - Mode bit 0 is single byte, 1 adds automatic multi-byte transfer.
// - Disabled: idle control 0 frees clock pin, 1 drives it high.
// - Clock select 0 uses external clock, 1..3 divide main clock by 4/8/16.
// - Reset clears mode, automatic control and interval registers.
// - Disabled port leaves both data pins to port use, and the clock pin unless idle control is 1, no transfer.
// - Receive enable 0 keeps data-in pin a port pin, transmit only.
// - Repeat bit 0 gives one-shot, 1 gives repeat operation.
// - Busy set by shift write, cleared at end, suspend or one-shot; code sets it only in repeat mode and never clears it at end.
// - Busy flag at bit 3 is read-only.
// - Interval control 1 uses five-bit field for gap; 0 ignores field.
// - Gap is 2.5 periods for n=0, else n+1.5 periods.
// - Stop mode performs no transfer and pins act as ports.
// - Shift out on falling, sample on rising, stop after eight, interrupt.
// - Start only on write while enabled and clock stopped or high.
// - Engine moves up to 16 bytes, pointer holds count-1, decrements.
// - Bit order is done by reversing written data, shift fixed.
`timescale 1ns/1ps
module acx_ctrl
  import acx_pkg::*;
#(
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // Processor byte bus.
  input  wire logic [15:0] cpu_addr,
  input  wire logic [7:0]  cpu_wdata,
  input  wire logic        cpu_wr,
  input  wire logic        cpu_bit_wr,
  input  wire logic [2:0]  cpu_bit_sel,
  input  wire logic        cpu_bit_val,
  input  wire logic        cpu_rd,
  output logic [7:0]       cpu_rdata_q,
  // Serial clock pin.
  input  wire logic        serial_clock_pin_in,
  output logic             serial_clock_pin_out_q,
  output logic             serial_clock_pin_oe_q,
  // Serial data pins.
  output logic             serial_data_out_pin_out_q,
  output logic             serial_data_out_pin_oe_q,
  input  wire logic        serial_data_in_pin_in,
  output logic             din_port_mode_q,
  // Transfer complete event.
  output logic             transfer_done_irq_q
);

  logic [7:0]  mode_q;
  logic [7:0]  ctrl_q;
  logic [7:0]  ival_q;
  logic        busy_q;
  logic [3:0]  ptr_q;
  logic [3:0]  ptr_start_q;
  logic [7:0]  sr_q;
  logic [3:0]  bit_cnt_q;
  logic        sck_q;
  logic        sclk_prev_q;
  logic [6:0]  gap_q;
  acx_state_e  state_q;
  logic [7:0]  buf_q [DEPTH];
  logic        port_en, lsb_first, auto_mode, idle_ctl, internal, din_own, rep;
  logic [1:0]  clk_sel;
  logic        wr_any, shift_wr, start, half_tick, fall_ev, rise_ev, din_bit;
  logic        byte_done, more;
  logic [6:0]  gap_len;
  logic [7:0]  rx_byte, rd_val;

  // Reverses the bit order of a byte.
  function automatic logic [7:0] acx_rev(input logic [7:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7-i];
    end
    return r;
  endfunction

  // Merges a whole-byte write or a single-bit write into a register value.
  function automatic logic [7:0] acx_merge(input logic [7:0] cur, input logic [7:0] wd,
                                           input logic full, input logic [2:0] bs,
                                           input logic bv);
    logic [7:0] r;
    r     = cur;
    r[bs] = bv;
    return full ? wd : r;
  endfunction

  // Control field decode.
  assign port_en   = mode_q[ACX_MODE_EN];
  assign lsb_first = mode_q[ACX_MODE_ORDER];
  assign auto_mode = mode_q[ACX_MODE_AUTO];
  assign idle_ctl  = mode_q[ACX_MODE_IDLE];
  assign clk_sel   = mode_q[ACX_MODE_SEL_HI:ACX_MODE_SEL_LO];
  assign internal  = clk_sel != ACX_SEL_EXT;
  assign din_own   = ctrl_q[ACX_CTRL_RX];
  assign rep       = ctrl_q[ACX_CTRL_REP];
  assign wr_any    = cpu_wr | cpu_bit_wr;
  assign shift_wr  = cpu_wr && (cpu_addr == ACX_ADDR_SHIFT);

  // A write starts a byte only when enabled and the clock is stopped or high.
  assign start = shift_wr && port_en && (state_q == ACX_IDLE) &&
                 (internal || serial_clock_pin_in);

  // Half period enables for the internal clock and the gap timer.
  acx_sclk_div u_div (
    .sys_clk     (sys_clk),
    .rstn        (rstn),
    .run         (port_en),
    .sel         (clk_sel),
    .half_tick_q (half_tick)
  );

  // Edge events come from the divider or from the external clock pin.
  assign fall_ev = internal ? (half_tick & sck_q) : (sclk_prev_q & ~serial_clock_pin_in);
  assign rise_ev = internal ? (half_tick & ~sck_q) : (~sclk_prev_q & serial_clock_pin_in);
  assign din_bit = din_own & serial_data_in_pin_in;
  assign rx_byte = {sr_q[6:0], din_bit};
  assign byte_done = (state_q == ACX_SHIFT) && rise_ev && (bit_cnt_q == ACX_BIT_LAST);
  assign more = auto_mode && ((ptr_q != 4'h0) || (rep && busy_q));

  // Gap length in half periods: 5 for n=0, 2n+3 otherwise, minimal when uncontrolled.
  assign gap_len = !ival_q[ACX_IVAL_EN] ? ACX_GAP_FREE :
                   (ival_q[ACX_IVAL_HI:0] == 5'h00) ? ACX_GAP_N0 :
                   {1'b0, ival_q[ACX_IVAL_HI:0], 1'b0} + ACX_GAP_EXTRA;

  // Mode register.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= ACX_RESET_VAL;
    end else if (wr_any && cpu_addr == ACX_ADDR_MODE) begin
      mode_q <= acx_merge(mode_q, cpu_wdata, cpu_wr, cpu_bit_sel, cpu_bit_val) &
                ACX_MODE_MASK;
    end
  end

  // Automatic control register; the busy position is never stored here.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= ACX_RESET_VAL;
    end else if (wr_any && cpu_addr == ACX_ADDR_CTRL) begin
      ctrl_q <= acx_merge(ctrl_q, cpu_wdata, cpu_wr, cpu_bit_sel, cpu_bit_val) &
                ACX_CTRL_WMASK;
    end
  end

  // Interval register.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ival_q <= ACX_RESET_VAL;
    end else if (wr_any && cpu_addr == ACX_ADDR_IVAL) begin
      ival_q <= acx_merge(ival_q, cpu_wdata, cpu_wr, cpu_bit_sel, cpu_bit_val) &
                ACX_IVAL_MASK;
    end
  end

  // Busy flag: set by a starting write in repeat mode, cleared on suspend or one-shot.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      busy_q <= 1'b0;
    end else if (start && auto_mode && rep) begin
      busy_q <= 1'b1;
    end else if (!port_en || !auto_mode || !rep) begin
      busy_q <= 1'b0;
    end
  end

  // Byte pointer holds count minus one and steps down per byte.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ptr_q       <= 4'h0;
      ptr_start_q <= 4'h0;
    end else if (wr_any && cpu_addr == ACX_ADDR_PTR) begin
      ptr_q <= 4'(acx_merge({4'h0, ptr_q}, cpu_wdata, cpu_wr, cpu_bit_sel, cpu_bit_val) &
                  ACX_PTR_MASK);
    end else if (start && auto_mode) begin
      ptr_start_q <= ptr_q;
    end else if (byte_done && auto_mode) begin
      ptr_q <= (ptr_q != 4'h0) ? ptr_q - 4'h1 : ptr_start_q;
    end
  end

  // Byte buffer, one process per entry; received bytes overwrite sent ones.
  for (genvar i = 0; i < DEPTH; i++) begin : g_buf
    always_ff @(posedge sys_clk) begin
      if (wr_any && cpu_addr[15:4] == ACX_ADDR_BUF[15:4] && cpu_addr[3:0] == 4'(i)) begin
        buf_q[i] <= acx_merge(buf_q[i], cpu_wdata, cpu_wr, cpu_bit_sel, cpu_bit_val);
      end else if (byte_done && auto_mode && din_own && ptr_q == 4'(i)) begin
        buf_q[i] <= lsb_first ? acx_rev(rx_byte) : rx_byte;
      end
    end
  end

  // External clock pin history for edge detection.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sclk_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= serial_clock_pin_in;
    end
  end

  // Shift engine.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q                   <= ACX_IDLE;
      sr_q                      <= 8'h00;
      bit_cnt_q                 <= 4'h0;
      sck_q                     <= 1'b1;
      serial_data_out_pin_out_q <= 1'b0;
      gap_q                     <= 7'h00;
      transfer_done_irq_q       <= 1'b0;
    end else if (!port_en) begin
      state_q             <= ACX_IDLE;
      bit_cnt_q           <= 4'h0;
      sck_q               <= 1'b1;
      transfer_done_irq_q <= 1'b0;
    end else begin
      transfer_done_irq_q <= 1'b0;
      case (state_q)
        ACX_IDLE: begin
          if (start) begin
            sr_q      <= auto_mode ? (lsb_first ? acx_rev(buf_q[ptr_q]) : buf_q[ptr_q])
                                   : (lsb_first ? acx_rev(cpu_wdata) : cpu_wdata);
            bit_cnt_q <= 4'h0;
            state_q   <= ACX_SHIFT;
          end
        end
        ACX_SHIFT: begin
          if (fall_ev) begin
            serial_data_out_pin_out_q <= sr_q[7];
            sck_q                     <= 1'b0;
          end
          if (rise_ev) begin
            sr_q      <= rx_byte;
            bit_cnt_q <= bit_cnt_q + 4'h1;
            sck_q     <= 1'b1;
          end
          if (byte_done) begin
            bit_cnt_q <= 4'h0;
            if (more) begin
              gap_q   <= gap_len;
              state_q <= ACX_GAP;
            end else begin
              transfer_done_irq_q <= 1'b1;
              state_q             <= ACX_IDLE;
            end
          end
        end
        ACX_GAP: begin
          if (!auto_mode) begin
            state_q <= ACX_IDLE;
          end else if (half_tick) begin
            if (gap_q <= 7'h01) begin
              sr_q    <= lsb_first ? acx_rev(buf_q[ptr_q]) : buf_q[ptr_q];
              state_q <= ACX_SHIFT;
            end else begin
              gap_q <= gap_q - 7'h01;
            end
          end
        end
        default: begin
          state_q <= ACX_IDLE;
        end
      endcase
    end
  end

  // Pin ownership and drive.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      serial_clock_pin_out_q   <= 1'b1;
      serial_clock_pin_oe_q    <= 1'b0;
      serial_data_out_pin_oe_q <= 1'b0;
      din_port_mode_q          <= 1'b1;
    end else begin
      serial_clock_pin_out_q   <= port_en ? sck_q : 1'b1;
      serial_clock_pin_oe_q    <= port_en ? internal : idle_ctl;
      serial_data_out_pin_oe_q <= port_en;
      din_port_mode_q          <= !(port_en && din_own);
    end
  end

  // Read value decode.
  always_comb begin
    rd_val = 8'h00;
    if (cpu_addr == ACX_ADDR_MODE) begin
      rd_val = mode_q;
    end else if (cpu_addr == ACX_ADDR_CTRL) begin
      rd_val                = ctrl_q;
      rd_val[ACX_CTRL_BUSY] = busy_q;
    end else if (cpu_addr == ACX_ADDR_IVAL) begin
      rd_val = ival_q;
    end else if (cpu_addr == ACX_ADDR_SHIFT) begin
      rd_val = lsb_first ? acx_rev(sr_q) : sr_q;
    end else if (cpu_addr == ACX_ADDR_PTR) begin
      rd_val = {4'h0, ptr_q};
    end else if (cpu_addr[15:4] == ACX_ADDR_BUF[15:4]) begin
      rd_val = buf_q[cpu_addr[3:0]];
    end
  end

  // Read data register, updated on each read strobe.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cpu_rdata_q <= 8'h00;
    end else if (cpu_rd) begin
      cpu_rdata_q <= rd_val;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_start_msb;
    start && !lsb_first && !auto_mode;
  endsequence

  sequence s_last_rise;
    (state_q == ACX_SHIFT) && rise_ev && (bit_cnt_q == ACX_BIT_LAST);
  endsequence

  AST_DISABLE_CLEARS: assert property (!port_en |=> state_q == ACX_IDLE && bit_cnt_q == 4'h0)
    else $error("Disabled port did not stop and clear the counter.");
  AST_IDLE_HIGH: assert property (!port_en && idle_ctl |=>
    serial_clock_pin_oe_q && serial_clock_pin_out_q)
    else $error("Idle clock pin not driven high.");
  AST_PINS_FREE: assert property (!port_en && !idle_ctl |=>
    !serial_clock_pin_oe_q && !serial_data_out_pin_oe_q && din_port_mode_q)
    else $error("Pins not released in stop mode.");
  AST_MSB_LOAD: assert property (s_start_msb |=> sr_q == $past(cpu_wdata))
    else $error("MSB-first load did not keep written order.");
  AST_LSB_LOAD: assert property (start && lsb_first && !auto_mode |=>
    sr_q == acx_rev($past(cpu_wdata)))
    else $error("LSB-first load was not reversed.");
  AST_BUSY_SOURCE: assert property ($rose(busy_q) |-> $past(shift_wr && port_en))
    else $error("Busy set without a shift register write.");
  AST_ONESHOT_IDLE: assert property (!rep |=> !busy_q)
    else $error("Busy flag high in one-shot mode.");
  AST_BUSY_RO: assert property (wr_any && cpu_addr == ACX_ADDR_CTRL && !start |=>
    busy_q == $past(busy_q) || !busy_q)
    else $error("Write changed the busy flag.");
  AST_DONE_IRQ: assert property (s_last_rise ##0 !more |=> transfer_done_irq_q ##1
    !transfer_done_irq_q)
    else $error("Done pulse missing after eighth bit.");
  AST_GAP_LOAD: assert property (s_last_rise ##0 more |=> state_q == ACX_GAP &&
    gap_q == $past(gap_len))
    else $error("Gap length not loaded.");
  AST_NO_RX: assert property ((state_q == ACX_SHIFT) && rise_ev && !din_own |=> !sr_q[0])
    else $error("Data-in sampled with reception disabled.");
  AST_START_GATE: assert property (shift_wr && !port_en |=> state_q == ACX_IDLE)
    else $error("Transfer started while disabled.");

endmodule // acx_ctrl

// *** verif/acx_peer.sv ***
`timescale 1ns/1ps
module acx_peer (
  // Serial lines as seen at the pins.
  input  wire logic        sck,
  input  wire logic        sdo,
  // Frame control from the bench.
  input  wire logic        load,
  input  wire logic        ext_go,
  input  wire logic [7:0]  tx,
  // Lines driven by the peer.
  output logic             sdi,
  output logic             ext_sck,
  output logic [15:0]      rx
);
  int n;

  // Start with the data line low, the clock line idle high and nothing received.
  initial begin
    sdi = 1'b0;
    ext_sck = 1'b1;
    rx = 16'h0000;
    n = 0;
  end

  // Drive our next bit on each fall and take the device's bit on each rise.
  always @(posedge load or sck) begin
    if (load) begin
      n = 0;
    end else if (sck === 1'b0) begin
      sdi = tx[7-n];
    end else if (sck === 1'b1) begin
      rx = {rx[14:0], sdo};
      n = (n + 1) % 8;
      if (n == 0) begin
        sdi <= #8 ~tx[0];  // Line released after the hold time shows the inverse.
      end
    end
  end

  // Slave clocking: eight slow periods whose edges land 1 ns after a system edge.
  // This keeps the line from moving in the time step where the device samples it.
  always @(posedge ext_go) begin
    #1;
    repeat (8) begin
      #20 ext_sck = 1'b0;
      #20 ext_sck = 1'b1;
    end
  end
endmodule // acx_peer

// *** verif/test_acx_ctrl.sv ***
`timescale 1ns/1ps
module test_acx_ctrl
  import acx_pkg::*;
;
  // Design inputs and outputs.
  logic        sys_clk = 1'b0;
  logic        rstn    = 1'b0;
  logic [15:0] addr    = 16'h0000;
  logic [7:0]  wdata   = 8'h00;
  logic        wr      = 1'b0;
  logic        bit_wr  = 1'b0;
  logic [2:0]  bit_sel = 3'h0;
  logic        bit_val = 1'b0;
  logic        rd      = 1'b0;
  logic [7:0]  rdata;
  logic        sck_out;
  logic        sck_oe;
  logic        sdo;
  logic        sdo_oe;
  logic        sdi;
  logic        din_port;
  logic        irq;
  // Peer control; the clock pin is the device's drive when its clock output enable is set, else the peer's.
  logic        ext_sck;
  logic        ld      = 1'b0;
  logic        ext_go  = 1'b0;
  logic [7:0]  ptx     = 8'h00;
  logic [15:0] prx;
  wire         sck_pin = sck_oe ? sck_out : ext_sck;
  // Bench bookkeeping.
  int          bad_count = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          irq_cnt = 0;
  int          last_fall = 0;
  int          max_gap = 0;
  bit          fresh = 1'b1;
  int          g0;
  int          g1;
  int          s;
  logic [7:0]  v;

  acx_ctrl i_acx_ctrl (
    .sys_clk                   (sys_clk),
    .rstn                      (rstn),
    .cpu_addr                  (addr),
    .cpu_wdata                 (wdata),
    .cpu_wr                    (wr),
    .cpu_bit_wr                (bit_wr),
    .cpu_bit_sel               (bit_sel),
    .cpu_bit_val               (bit_val),
    .cpu_rd                    (rd),
    .cpu_rdata_q               (rdata),
    .serial_clock_pin_in       (sck_pin),
    .serial_clock_pin_out_q    (sck_out),
    .serial_clock_pin_oe_q     (sck_oe),
    .serial_data_out_pin_out_q (sdo),
    .serial_data_out_pin_oe_q  (sdo_oe),
    .serial_data_in_pin_in     (sdi),
    .din_port_mode_q           (din_port),
    .transfer_done_irq_q       (irq)
  );

  acx_peer i_acx_peer (
    .sck     (sck_pin),
    .sdo     (sdo),
    .load    (ld),
    .ext_go  (ext_go),
    .tx      (ptx),
    .sdi     (sdi),
    .ext_sck (ext_sck),
    .rx      (prx)
  );

  // The 200 MHz system clock.
  always #2.5 sys_clk = ~sys_clk;

  // Count cycles and completion pulses.
  always @(posedge sys_clk) begin
    cyc++;
    if (irq === 1'b1) irq_cnt++;
  end

  // Track the widest spacing between clock-pin falls since the last start.
  always @(negedge sck_pin) begin
    if (!fresh && cyc - last_fall > max_gap) max_gap = cyc - last_fall;
    fresh = 1'b0;
    last_fall = cyc;
  end

  // Print the verdict and stop.
  task automatic end_of_test();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Compare a seen byte with the expected one.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Let n edges pass and step past their updates.
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Whole-byte write, one strobe cycle.
  task automatic wr8(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  // Single-bit write.
  task automatic bitw(input logic [15:0] a, input logic [2:0] b, input logic val);
    @(posedge sys_clk);
    addr <= a;
    bit_sel <= b;
    bit_val <= val;
    bit_wr <= 1'b1;
    @(posedge sys_clk);
    bit_wr <= 1'b0;
  endtask

  // Byte read; data is registered one cycle after the strobe.
  task automatic rd8(input logic [15:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(posedge sys_clk);
    #1 d = rdata;
  endtask

  // Read and compare.
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd8(a, d);
    chk(d, e);
  endtask

  // Arm the peer with its byte, then start by writing the shift register.
  task automatic xfer(input logic [7:0] t, input logic [7:0] d);
    @(posedge sys_clk);
    ptx <= t;
    ld <= 1'b1;
    @(posedge sys_clk);
    ld <= 1'b0;
    fresh = 1'b1;
    max_gap = 0;
    wr8(ACX_ADDR_SHIFT, d);
  endtask

  // Wait for a completion pulse under a bound.
  task automatic wait_irq(input int lim);
    int c;
    c = irq_cnt;
    for (int i = 0; i < lim && irq_cnt == c; i++) @(posedge sys_clk);
    #1;
    if (irq_cnt == c) begin
      bad_count++;
      end_of_test();
    end
  endtask

  // Two-byte one-shot automatic run; returns the widest fall spacing.
  task automatic auto_run(input logic [7:0] iv, output int g);
    wr8(ACX_ADDR_IVAL, iv);
    wr8(ACX_ADDR_PTR, 8'h01);
    wr8(ACX_ADDR_BUF, 8'h22);
    wr8(ACX_ADDR_BUF + 16'h0001, 8'h11);
    xfer(8'h5a, 8'h00);
    rdc(ACX_ADDR_CTRL, 8'h80);
    wait_irq(600);
    g = max_gap;
  endtask

  // Main sequence: reset, registers, pins, transfers, automatic engine.
  initial begin
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    rdc(ACX_ADDR_MODE, 8'h00);
    rdc(ACX_ADDR_CTRL, 8'h00);
    rdc(ACX_ADDR_IVAL, 8'h00);
    chk({6'h00, sdo_oe, din_port}, 8'h01);
    wr8(ACX_ADDR_MODE, 8'h73);
    rdc(ACX_ADDR_MODE, 8'h73);
    wr8(ACX_ADDR_CTRL, 8'hc8);
    rdc(ACX_ADDR_CTRL, 8'hc0);
    wr8(ACX_ADDR_IVAL, 8'h9f);
    rdc(ACX_ADDR_IVAL, 8'h9f);
    bitw(ACX_ADDR_IVAL, 3'h7, 1'b0);
    rdc(ACX_ADDR_IVAL, 8'h1f);
    rdc(16'hff70, 8'h00);
    wr8(ACX_ADDR_MODE, 8'h10);
    idle(3);
    chk({6'h00, sck_oe, sck_out}, 8'h03);
    wr8(ACX_ADDR_MODE, 8'h00);
    idle(3);
    chk({6'h00, sck_oe, sdo_oe}, 8'h00);
    // A write while disabled must not start once the port is enabled.
    g0 = irq_cnt;
    wr8(ACX_ADDR_SHIFT, 8'h77);
    wr8(ACX_ADDR_MODE, 8'h81);
    idle(60);
    chk(8'(irq_cnt - g0), 8'h00);
    // Disabling mid-byte aborts with no completion and frees the pins.
    wr8(ACX_ADDR_CTRL, 8'h80);
    wr8(ACX_ADDR_MODE, 8'h83);
    xfer(8'h00, 8'hff);
    idle(40);
    wr8(ACX_ADDR_MODE, 8'h03);
    idle(200);
    chk(8'(irq_cnt - g0), 8'h00);
    chk({6'h00, sck_oe, sdo_oe}, 8'h00);
    // Every divided clock, MSB first.
    for (s = 1; s < 4; s++) begin
      wr8(ACX_ADDR_MODE, 8'h80 | 8'(s));
      xfer(8'h35, 8'h1e);
      wait_irq(400);
      chk(8'(max_gap), 8'(2 << s));
      chk(prx[7:0], 8'h1e);
      rdc(ACX_ADDR_SHIFT, 8'h35);
    end
    chk({7'h00, din_port}, 8'h00);
    wr8(ACX_ADDR_MODE, 8'hc1);
    xfer(8'h35, 8'h1e);
    wait_irq(400);
    chk(prx[7:0], 8'h78);
    rdc(ACX_ADDR_SHIFT, 8'hac);
    // Receive disabled: data-in stays a port pin and reads as zeros.
    wr8(ACX_ADDR_CTRL, 8'h00);
    wr8(ACX_ADDR_MODE, 8'h81);
    idle(3);
    chk({7'h00, din_port}, 8'h01);
    xfer(8'hff, 8'h00);
    wait_irq(400);
    rdc(ACX_ADDR_SHIFT, 8'h00);
    // External clock from the peer.
    wr8(ACX_ADDR_CTRL, 8'h80);
    wr8(ACX_ADDR_MODE, 8'h80);
    xfer(8'hc3, 8'h96);
    @(posedge sys_clk);
    ext_go <= 1'b1;
    @(posedge sys_clk);
    ext_go <= 1'b0;
    wait_irq(600);
    chk(prx[7:0], 8'h96);
    rdc(ACX_ADDR_SHIFT, 8'hc3);
    chk({7'h00, sck_oe}, 8'h00);
    // Automatic mode gaps with and without interval control.
    wr8(ACX_ADDR_MODE, 8'ha1);
    auto_run(8'h80, g0);
    auto_run(8'h83, g1);
    chk(8'(g1 - g0), 8'h08);
    auto_run(8'h00, g0);
    auto_run(8'h03, g1);
    chk(8'(g1 - g0), 8'h00);
    chk(prx[15:8], 8'h11);
    chk(prx[7:0], 8'h22);
    rdc(ACX_ADDR_BUF + 16'h0001, 8'h5a);
    // Repeat mode: busy while running, polled until it clears.
    wr8(ACX_ADDR_CTRL, 8'hc0);
    wr8(ACX_ADDR_PTR, 8'h00);
    xfer(8'h00, 8'h00);
    rdc(ACX_ADDR_CTRL, 8'hc8);
    bitw(ACX_ADDR_CTRL, 3'h6, 1'b0);
    v = 8'h08;
    for (int i = 0; i < 50 && v[3] !== 1'b0; i++) rd8(ACX_ADDR_CTRL, v);
    chk(v, 8'h80);
    end_of_test();
  end
endmodule // test_acx_ctrl
